// ===== src/rsq_pkg.sv
/*
  Constants, register map and state codes of the reset sequencer.
  Assumes a single 200 MHz base clock; one cycle of it is one base-clock cycle.
*/
package rsq_pkg;

  // Timing in base-clock cycles.
  localparam int unsigned PIN_LOW_MIN_CYC  = 67;
  localparam int unsigned PIN_LOW_POR_CYC  = 4163;
  localparam int unsigned DRIVE_CYC        = 32;
  localparam int unsigned EXTEND_CYC       = 32;
  localparam int unsigned POR_HOLD_CYC     = 4096;
  localparam int unsigned CNT_W            = 13;

  // Reset start vectors.
  localparam logic [15:0] VEC_USER    = 16'hFFFE;
  localparam logic [15:0] VEC_MONITOR = 16'hFEFE;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_CONFIG  = 8'h04;
  localparam logic [7:0] OFS_KICK    = 8'h08;
  localparam logic [7:0] OFS_CYCLE   = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h14;

  // Reset status bit positions.
  localparam int unsigned BIT_POR = 0;
  localparam int unsigned BIT_PIN = 1;
  localparam int unsigned BIT_WDG = 2;
  localparam int unsigned BIT_LVI = 3;
  localparam int unsigned BIT_OPC = 4;
  localparam int unsigned BIT_ADR = 5;
  localparam int unsigned NSRC    = 6;

  // Configuration: bit 0 is the watchdog disable bit.
  localparam int unsigned CFG_WDG_DIS = 0;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
  localparam logic [31:0] KICK_KEY    = 32'h0000_00A5;
  localparam int unsigned WDG_W       = 18;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    RSQ_IDLE   = 4'b0001,
    RSQ_PORHLD = 4'b0010,
    RSQ_DRIVE  = 4'b0100,
    RSQ_EXTEND = 4'b1000
  } rsq_state_t;

endpackage : rsq_pkg

// ===== src/rsq_sync.sv
/*
  Two flip-flop synchroniser for one level.
  Assumes the input may change at any time relative to the clock.
*/
`timescale 1ns/1ps
module rsq_sync (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Level
  input  wire logic din,
  output logic      dout
);
  logic stage1;

  // Resets to one because the pins it serves idle high.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stage1 <= 1'b1;
      dout   <= 1'b1;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : rsq_sync

// ===== src/rsq_watchdog.sv
/*
  Free-running watchdog counter raising a one-cycle overflow request.
  Assumes enable and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
module rsq_watchdog (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Control
  input  wire logic enable,
  input  wire logic clear,
  // Status
  output logic [rsq_pkg::WDG_W-1:0] count,
  output logic                      overflow
);
  import rsq_pkg::*;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      count    <= '0;
      overflow <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (!enable || clear) begin
        count <= '0;
      end else begin
        count <= count + 1'b1;
        if (&count) begin
          overflow <= 1'b1;
        end
      end
    end
  end
endmodule : rsq_watchdog

// ===== src/rsq_top.sv
/*
  Reset sequencer: gathers six reset sources, drives the shared reset pin,
  times the internal reset, records the cause and hosts the watchdog.
  Assumes a 200 MHz ref_clk, an open-drain reset pin with external pull-up,
  and AXI4-Lite register access from a master on ref_clk.
*/
`timescale 1ns/1ps
module rsq_top (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // Reset sources
  input  wire logic        low_voltage_inhibit,
  input  wire logic        illegal_opcode,
  input  wire logic        illegal_address,
  // Mode
  input  wire logic        monitor_mode,
  input  wire logic        test_high_voltage,
  // Open-drain reset pin
  input  wire logic        rst_pin_i,
  output logic             rst_pin_o,
  output logic             rst_pin_oe,
  // Outputs to the core
  output logic             internal_reset_line,
  output logic             halt,
  output logic [15:0]      reset_vector,
  output logic             watchdog_enable,
  output logic             irq,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import rsq_pkg::*;

  rsq_state_t           state;
  logic [CNT_W-1:0]     seq_cnt;
  logic [CNT_W-1:0]     low_cnt;
  logic                 por_active;
  logic                 pin_sync;
  logic [NSRC-1:0]      reset_status_reg;
  logic [31:0]          first_config_reg;
  logic [31:0]          cycle_cnt;
  logic [NSRC-1:0]      irq_sts;
  logic [NSRC-1:0]      irq_msk;
  logic                 wdg_ovf;
  logic                 wdg_clear;
  logic [WDG_W-1:0]     wdg_count;
  logic                 int_req;
  logic [NSRC-1:0]      src_event;
  logic                 pin_flag_set;
  logic                 aw_held;
  logic                 w_held;
  logic [7:0]           aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 do_write;
  logic                 hv_seen;
  logic                 hv_sync;
  logic                 por_pin;

  // Pin halts at once, independent of the clock.
  assign halt = ~rst_pin_i | internal_reset_line;

  rsq_sync u_pin_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .din     (rst_pin_i),
    .dout    (pin_sync)
  );

  // Watchdog runs when not disabled, outside monitor mode or once the test voltage has been removed in monitor mode.
  assign watchdog_enable = ~first_config_reg[CFG_WDG_DIS] & (~monitor_mode | hv_seen);

  rsq_watchdog u_wdg (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .enable   (watchdog_enable & ~internal_reset_line),
    .clear    (wdg_clear),
    .count    (wdg_count),
    .overflow (wdg_ovf)
  );

  // The test voltage is a pin level, so it is synchronised before it is trusted.
  rsq_sync u_hv_sync (
    .ref_clk (ref_clk),
    .reset   (reset),
    .din     (test_high_voltage),
    .dout    (hv_sync)
  );

  // Test voltage removal latches the enable for the rest of the session.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hv_seen <= 1'b0;
    end else if (!hv_sync && monitor_mode) begin
      hv_seen <= 1'b1;
    end
  end

  // Internal sources start the pin-drive sequence.
  // A late overflow is masked by the enable, so a fresh disable wins at once.
  assign int_req = (wdg_ovf & watchdog_enable) | low_voltage_inhibit | illegal_opcode |
                   illegal_address;

  // Sequencer: power-on hold, pin drive, extension.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state      <= RSQ_PORHLD;
      seq_cnt    <= '0;
      por_active <= 1'b1;
    end else begin
      case (state)
        RSQ_IDLE: begin
          seq_cnt <= '0;
          if (int_req) begin
            state <= RSQ_DRIVE;
          end
        end
        RSQ_PORHLD: begin
          if (seq_cnt == CNT_W'(POR_HOLD_CYC - 1)) begin
            seq_cnt <= '0;
            state   <= RSQ_DRIVE;
          end else begin
            seq_cnt <= seq_cnt + 1'b1;
          end
        end
        RSQ_DRIVE: begin
          if (seq_cnt == CNT_W'(DRIVE_CYC - 1)) begin
            seq_cnt <= '0;
            state   <= RSQ_EXTEND;
          end else begin
            seq_cnt <= seq_cnt + 1'b1;
          end
        end
        RSQ_EXTEND: begin
          if (seq_cnt == CNT_W'(EXTEND_CYC - 1)) begin
            seq_cnt    <= '0;
            por_active <= 1'b0;
            state      <= RSQ_IDLE;
          end else begin
            seq_cnt <= seq_cnt + 1'b1;
          end
        end
        default: begin
          state <= RSQ_IDLE;
        end
      endcase
    end
  end

  assign rst_pin_o  = 1'b0;
  assign rst_pin_oe = (state == RSQ_PORHLD) || (state == RSQ_DRIVE);
  // Pin low from outside also holds the line, so the core stays reset.
  assign internal_reset_line = (state != RSQ_IDLE) || !pin_sync;
  assign reset_vector = monitor_mode ? VEC_MONITOR : VEC_USER;

  // Pin-low duration counter; saturates. Outside power-on only external lows count,
  // during power-on the device's own drive counts as well.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      low_cnt <= '0;
    end else if (pin_sync || (rst_pin_oe && !por_pin)) begin
      low_cnt <= '0;
    end else if (!(&low_cnt)) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  // The long pin count applies from power-on until pin and sequencer are both idle.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      por_pin <= 1'b1;
    end else if (pin_sync && state == RSQ_IDLE) begin
      por_pin <= 1'b0;
    end
  end

  assign pin_flag_set = por_pin ? (low_cnt == CNT_W'(PIN_LOW_POR_CYC - 1))
                                   : (low_cnt == CNT_W'(PIN_LOW_MIN_CYC - 1));

  always_comb begin
    src_event          = '0;
    src_event[BIT_POR] = (state == RSQ_PORHLD) && (seq_cnt == '0);
    src_event[BIT_PIN] = pin_flag_set && !pin_sync && (por_pin || !rst_pin_oe);
    src_event[BIT_WDG] = wdg_ovf && watchdog_enable;
    src_event[BIT_LVI] = low_voltage_inhibit;
    src_event[BIT_OPC] = illegal_opcode;
    src_event[BIT_ADR] = illegal_address;
  end

  // Flags record the last cause; a new reset replaces older causes.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reset_status_reg <= '0;
    end else if (|src_event) begin
      reset_status_reg <= src_event;
    end
  end

  // Cycle counter: cleared by power-on and internal-source resets only, not by pin resets.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cycle_cnt <= '0;
    end else if (state != RSQ_IDLE) begin
      cycle_cnt <= '0;
    end else begin
      cycle_cnt <= cycle_cnt + 1'b1;
    end
  end

  // AXI write channel: address and data taken in any order.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == OFS_STATUS || aw_addr == OFS_CONFIG || aw_addr == OFS_KICK ||
            aw_addr == OFS_CYCLE || aw_addr == OFS_IRQ_STS || aw_addr == OFS_IRQ_MSK) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; the kick needs a key so stray writes cannot feed the watchdog.
  assign wdg_clear = do_write && aw_addr == OFS_KICK && w_strb[0] && w_data[7:0] == KICK_KEY[7:0];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      first_config_reg <= CFG_RESET;
      irq_msk          <= '0;
    end else if (do_write) begin
      if (aw_addr == OFS_CONFIG && w_strb[0]) begin
        first_config_reg[7:0] <= w_data[7:0];
      end else if (aw_addr == OFS_IRQ_MSK && w_strb[0]) begin
        irq_msk <= w_data[NSRC-1:0];
      end
    end
  end

  // Sticky interrupt flags; a new event wins over a write-one clear.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq_sts <= '0;
    end else if (do_write && aw_addr == OFS_IRQ_STS && w_strb[0]) begin
      irq_sts <= (irq_sts & ~w_data[NSRC-1:0]) | src_event;
    end else begin
      irq_sts <= irq_sts | src_event;
    end
  end

  assign irq = |(irq_sts & irq_msk);

  // AXI read channel, one-cycle answer.
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= '0;
      if (s_axi_araddr == OFS_STATUS) begin
        s_axi_rdata <= 32'(reset_status_reg);
      end else if (s_axi_araddr == OFS_CONFIG) begin
        s_axi_rdata <= first_config_reg;
      end else if (s_axi_araddr == OFS_KICK) begin
        s_axi_rdata <= 32'(wdg_count);
      end else if (s_axi_araddr == OFS_CYCLE) begin
        s_axi_rdata <= cycle_cnt;
      end else if (s_axi_araddr == OFS_IRQ_STS) begin
        s_axi_rdata <= 32'(irq_sts);
      end else if (s_axi_araddr == OFS_IRQ_MSK) begin
        s_axi_rdata <= 32'(irq_msk);
      end else begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks.
  drive_len_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(state == RSQ_DRIVE) |-> ##31 (state == RSQ_DRIVE && rst_pin_oe) ##1 !rst_pin_oe)
    else $error("pin drive ended early");
  extend_after_a: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(rst_pin_oe) |-> internal_reset_line ##31 (state == RSQ_EXTEND) ##1 (state == RSQ_IDLE))
    else $error("extension length wrong");
  int_src_a: assert property (@(posedge ref_clk) disable iff (reset)
    (int_req && state == RSQ_IDLE) |=> internal_reset_line && rst_pin_oe)
    else $error("internal source did not reset");
  halt_pin_a: assert property (@(posedge ref_clk) disable iff (reset)
    !rst_pin_i |-> halt)
    else $error("halt missing with pin low");
  cycle_clr_a: assert property (@(posedge ref_clk) disable iff (reset)
    (state == RSQ_DRIVE) |=> cycle_cnt == '0)
    else $error("cycle counter not cleared");
  pin_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
    (!por_pin && low_cnt == CNT_W'(PIN_LOW_MIN_CYC - 1) && !pin_sync && !rst_pin_oe)
      |=> reset_status_reg[BIT_PIN])
    else $error("pin flag not set after 67 cycles");
  pin_por_a: assert property (@(posedge ref_clk) disable iff (reset)
    (por_pin && low_cnt == CNT_W'(PIN_LOW_POR_CYC - 1) && !pin_sync)
      |=> reset_status_reg[BIT_PIN])
    else $error("pin flag not set after long count");
  wdg_dis_a: assert property (@(posedge ref_clk) disable iff (reset)
    first_config_reg[CFG_WDG_DIS] |=> !wdg_ovf)
    else $error("watchdog fired while disabled");
  vec_sel_a: assert property (@(posedge ref_clk) disable iff (reset)
    monitor_mode |-> reset_vector == VEC_MONITOR)
    else $error("monitor vector wrong");
  irq_lvl_a: assert property (@(posedge ref_clk) disable iff (reset)
    |(irq_sts & irq_msk) |-> irq)
    else $error("interrupt not raised");
  irq_set_a: assert property (@(posedge ref_clk) disable iff (reset)
    |src_event |=> (irq_sts & $past(src_event)) == $past(src_event))
    else $error("event not recorded in interrupt status");

  por_done_c: cover property (@(posedge ref_clk) disable iff (reset) $fell(por_active));
  wdg_rst_c:  cover property (@(posedge ref_clk) disable iff (reset) wdg_ovf);
  pin_rst_c:  cover property (@(posedge ref_clk) disable iff (reset) src_event[BIT_PIN]);
endmodule : rsq_top

// ===== sim/rsq_pin_model.sv
/*
  Board side of the shared open-drain reset pin: a pull-up and an external switch.
  Assumes the device only ever pulls the pin low, while rst_pin_oe is high.
*/
`timescale 1ns/1ps
module rsq_pin_model (
  // Device side
  input  wire logic rst_pin_o,
  input  wire logic rst_pin_oe,
  // External switch, high pulls the pin low
  input  wire logic ext_low,
  // Resolved pin level
  output logic      rst_pin_i
);
  // The pull-up wins when nobody drives, so a released pin never keeps a stale low.
  // The switch may close at any moment, with no regard to the clock.
  assign rst_pin_i = ((rst_pin_oe && !rst_pin_o) || ext_low) ? 1'b0 : 1'b1;
endmodule : rsq_pin_model

// ===== sim/reset_sequencer_with_watchdog_bench.sv
/*
  Self-checking bench of the reset sequencer: power-on, internal sources, pin resets,
  mode outputs and registers over AXI4-Lite.
  Assumes rsq_pkg, rsq_top and rsq_pin_model are compiled before this file.
*/
`timescale 1ns/1ps
module reset_sequencer_with_watchdog_bench;
  import rsq_pkg::*;
  logic ref_clk, reset, low_voltage_inhibit, illegal_opcode, illegal_address;
  logic monitor_mode, test_high_voltage, ext_low, rst_pin_i, rst_pin_o, rst_pin_oe;
  logic internal_reset_line, halt, watchdog_enable, irq;
  logic [15:0] reset_vector;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, c0;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int failures, checks_done, cycles, oe_n, ext_n;
  logic [2:0]  row_src [3] = '{3'b001, 3'b010, 3'b100};
  logic [31:0] row_sts [3] = '{32'h0000_0008, 32'h0000_0010, 32'h0000_0020};

  rsq_top dut (
    .ref_clk(ref_clk), .reset(reset), .low_voltage_inhibit(low_voltage_inhibit),
    .illegal_opcode(illegal_opcode), .illegal_address(illegal_address),
    .monitor_mode(monitor_mode), .test_high_voltage(test_high_voltage),
    .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
    .internal_reset_line(internal_reset_line), .halt(halt), .reset_vector(reset_vector),
    .watchdog_enable(watchdog_enable), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  rsq_pin_model board (.rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .ext_low(ext_low),
                       .rst_pin_i(rst_pin_i));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict

  // The whole run needs under 15000 cycles; a hang is cut off well beyond that.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Requests start just after a rising edge; each handshake is judged at a rising edge
  // on the values that stand before it, and released by that same edge.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd

  // Counts the cycles of pin drive, then the cycles the line outlasts it.
  task automatic measure(output int oe_c, output int ext_c);
    oe_c = 0;
    ext_c = 0;
    @(negedge ref_clk);
    while (rst_pin_oe !== 1'b1) @(negedge ref_clk);
    while (rst_pin_oe === 1'b1) begin
      oe_c++;
      @(negedge ref_clk);
    end
    while (internal_reset_line === 1'b1) begin
      ext_c++;
      @(negedge ref_clk);
    end
  endtask : measure

  task automatic pin_pulse(input int n);
    @(posedge ref_clk);
    ext_low <= 1'b1;
    #1 check(halt, 1'b1);
    repeat (n) @(posedge ref_clk);
    ext_low <= 1'b0;
    while (internal_reset_line !== 1'b0) @(negedge ref_clk);
  endtask : pin_pulse

  initial begin
    {reset, monitor_mode, test_high_voltage} = 3'b111;
    {low_voltage_inhibit, illegal_opcode, illegal_address, ext_low} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    measure(oe_n, ext_n);
    check(oe_n, POR_HOLD_CYC + DRIVE_CYC);
    check(ext_n >= EXTEND_CYC && ext_n <= EXTEND_CYC + 3, 1'b1);
    check(reset_vector, VEC_MONITOR);
    check(watchdog_enable, 1'b0);
    axi_rd(OFS_STATUS, d, r);
    check(d, 32'h0000_0001);
    test_high_voltage <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check(watchdog_enable, 1'b1);
    monitor_mode <= 1'b0;
    @(negedge ref_clk);
    check(watchdog_enable, 1'b1);
    check(reset_vector, VEC_USER);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      {illegal_address, illegal_opcode, low_voltage_inhibit} <= row_src[i];
      @(posedge ref_clk);
      {illegal_address, illegal_opcode, low_voltage_inhibit} <= 3'b000;
      measure(oe_n, ext_n);
      check(oe_n, DRIVE_CYC);
      check(ext_n >= EXTEND_CYC && ext_n <= EXTEND_CYC + 3, 1'b1);
      axi_rd(OFS_STATUS, d, r);
      check(d, row_sts[i]);
      axi_rd(OFS_CYCLE, d, r);
      check(d < 32'h0000_0100, 1'b1);
    end
    // Interrupt on the last recorded cause: masked, unmasked, then cleared.
    axi_wr(OFS_IRQ_MSK, 32'h0000_0000, r);
    @(negedge ref_clk);
    check(irq, 1'b0);
    axi_wr(OFS_IRQ_MSK, row_sts[2], r);
    @(negedge ref_clk);
    check(irq, 1'b1);
    axi_wr(OFS_IRQ_STS, row_sts[2], r);
    @(negedge ref_clk);
    check(irq, 1'b0);
    axi_wr(OFS_CONFIG, 32'h0000_0001, r);
    axi_rd(OFS_CONFIG, d, r);
    check(d, 32'h0000_0001);
    axi_wr(OFS_KICK, KICK_KEY, r);
    check(r, RESP_OKAY);
    axi_rd(8'h20, d, r);
    check(r, RESP_SLVERR);
    axi_wr(8'h24, 32'h0000_FFFF, r);
    check(r, RESP_SLVERR);
    // A pin pulse shorter than the minimum must not be taken for a pin reset.
    pin_pulse(40);
    axi_rd(OFS_STATUS, d, r);
    check(d[BIT_PIN], 1'b0);
    axi_rd(OFS_CYCLE, c0, r);
    pin_pulse(PIN_LOW_MIN_CYC + 8);
    axi_rd(OFS_STATUS, d, r);
    check(d[BIT_PIN], 1'b1);
    axi_rd(OFS_CYCLE, d, r);
    check(d > c0, 1'b1);
    check(rst_pin_oe, 1'b0);
    // Power-on again with the pin held from outside: first too short, then long enough.
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      reset <= 1'b1;
      ext_low <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (k ? PIN_LOW_POR_CYC + 8 : POR_HOLD_CYC) @(posedge ref_clk);
      ext_low <= 1'b0;
      while (internal_reset_line !== 1'b0) @(negedge ref_clk);
      axi_rd(OFS_STATUS, d, r);
      check(d[BIT_PIN], k[0]);
    end
    print_verdict();
  end
endmodule : reset_sequencer_with_watchdog_bench
